// file: core/burst2_sram_device.sv
// Memory device end: double-rate capture, late-write buffer, array and read launch.
//
// Summary of operation
// (R01) Every access moves exactly two words.
// (R02) Separate read and write data ports.
// (R03) Main input clock rise starts each operation.
// (R04) Main rise takes read address, strobes, word one.
// (R05) Inverse rise takes write address, word two.
// (R06) Lane gates apply per word, per byte.
// (R07) Buffer holds write data until address.
// (R08) Controller drives word one, then word two.
// (R09) First read word leaves 1.5 cycles later.
// (R10) Second read word on next output edge.
// (R11) Output clocks high: time from input clocks.
// (R12) Return strobes travel with read data.
// (R13) Retrieve strobe low starts a read.
// (R14) Store strobe low starts a write.
// (R15) Lane gates active low, sampled with data.
// (R16) Loop bypass low: latency one cycle.
// (R17) Reads see pending buffered write bytes.
// (R18) Each lane gate covers nine bits.
`timescale 1ns/1ps
module burst2_sram_device
  import sram_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  sram_link_if.device link,
  output logic lat_bypass_out,
  output logic buffer_hit_out
);
  localparam int SYNC_W = 7 + LANES + ADDR_W + WORD_W;

  logic [WORD_W-1:0] mem [0:ARRAY_WORDS-1];
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [3:0] clk_prev;
  logic wpend;
  logic [WORD_W-1:0] wdata0;
  logic [LANES-1:0] wgate0;
  logic buf_valid;
  logic [ADDR_W-1:0] buf_addr;
  logic [WORD_W-1:0] buf_d0;
  logic [WORD_W-1:0] buf_d1;
  logic [LANES-1:0] buf_g0;
  logic [LANES-1:0] buf_g1;
  logic [BURST_W-1:0] fifo [0:1];
  logic fifo_wp;
  logic fifo_rp;
  logic [1:0] fifo_cnt;
  logic tok;
  logic [1:0] pipe;
  logic second_due;

  wire logic [SYNC_W-1:0] pin_vec = {link.input_timing_main, link.input_timing_inverse,
    link.output_timing_main, link.output_timing_inverse, link.retrieve_strobe_n,
    link.store_strobe_n, link.loop_bypass_n, link.lane_write_gate_n,
    link.memory_pointer_in, link.write_word};

  // Pins come from another clock domain, so two flops stand before any logic.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pin_vec;
      sync2 <= sync1;
    end
  end

  wire logic s_k;
  wire logic s_kinv;
  wire logic s_c;
  wire logic s_cinv;
  wire logic s_rd_n;
  wire logic s_wr_n;
  wire logic s_byp_n;
  wire logic [LANES-1:0] s_gate_n;
  wire logic [ADDR_W-1:0] s_addr;
  wire logic [WORD_W-1:0] s_data;
  assign {s_k, s_kinv, s_c, s_cinv, s_rd_n, s_wr_n, s_byp_n, s_gate_n, s_addr, s_data} = sync2;

  wire logic k_rise = s_k & ~clk_prev[3]; // (R03)
  wire logic kinv_rise = s_kinv & ~clk_prev[2];
  wire logic c_rise = s_c & ~clk_prev[1];
  wire logic cinv_rise = s_cinv & ~clk_prev[0];
  wire logic tied = s_c & s_cinv; // (R11)
  wire logic o_main = tied ? s_k : s_c;
  wire logic o_inv = tied ? s_kinv : s_cinv;
  wire logic o_edge = tied ? (k_rise | kinv_rise) : (c_rise | cinv_rise);

  wire logic take_write = k_rise & ~s_wr_n; // (R14)
  wire logic take_waddr = kinv_rise & wpend; // (R05)
  wire logic commit = take_waddr & buf_valid;
  wire logic push = k_rise & ~s_rd_n & (fifo_cnt != SLOT_COUNT); // (R13)
  wire logic launch0 = o_edge & (s_byp_n ? pipe[1] : pipe[0]); // (R09) (R16)
  wire logic launch1 = o_edge & second_due; // (R10)

  // Array read for both burst words, with any still-buffered write merged on top.
  wire logic [ADDR_W:0] rd_idx0 = {s_addr, 1'b0};
  wire logic [ADDR_W:0] rd_idx1 = {s_addr, 1'b1};
  wire logic hit = buf_valid & (buf_addr == s_addr);
  wire logic [WORD_W-1:0] arr0 = mem[rd_idx0];
  wire logic [WORD_W-1:0] arr1 = mem[rd_idx1];
  wire logic [WORD_W-1:0] rd0 = hit ? lane_merge(arr0, buf_d0, buf_g0) : arr0; // (R17)
  wire logic [WORD_W-1:0] rd1 = hit ? lane_merge(arr1, buf_d1, buf_g1) : arr1; // (R17)
  wire logic [BURST_W-1:0] head = fifo[fifo_rp];
  wire logic [ADDR_W:0] wr_idx0 = {buf_addr, 1'b0};
  wire logic [ADDR_W:0] wr_idx1 = {buf_addr, 1'b1};

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clk_prev <= '0;
    end
    else
    begin
      clk_prev <= {s_k, s_kinv, s_c, s_cinv};
    end
  end

  // Word one and its gates arrive half a cycle before the write address.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wpend <= 1'b0;
      wdata0 <= '0;
      wgate0 <= '0;
    end
    else if (take_write)
    begin
      wpend <= 1'b1; // (R07)
      wdata0 <= s_data; // (R04)
      wgate0 <= s_gate_n; // (R15)
    end
    else if (take_waddr)
    begin
      wpend <= 1'b0;
    end
  end

  // The buffered write only reaches the array when the next write address arrives.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      buf_valid <= 1'b0;
      buf_addr <= '0;
      buf_d0 <= '0;
      buf_d1 <= '0;
      buf_g0 <= '0;
      buf_g1 <= '0;
    end
    else if (take_waddr)
    begin
      buf_valid <= 1'b1; // (R07)
      buf_addr <= s_addr; // (R05)
      buf_d0 <= wdata0;
      buf_d1 <= s_data; // (R01)
      buf_g0 <= wgate0;
      buf_g1 <= s_gate_n; // (R06)
    end
  end

  // Each gate guards one nine-bit lane of its own burst word.
  always_ff @(posedge clk_in)
  begin
    if (commit)
    begin
      mem[wr_idx0] <= lane_merge(mem[wr_idx0], buf_d0, buf_g0); // (R06) (R18)
      mem[wr_idx1] <= lane_merge(mem[wr_idx1], buf_d1, buf_g1); // (R06) (R18)
    end
  end

  // Read bursts queue here so write traffic never blocks them.
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      fifo[fifo_wp] <= {rd1, rd0}; // (R02)
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fifo_wp <= 1'b0;
      fifo_rp <= 1'b0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (push)
      begin
        fifo_wp <= ~fifo_wp;
      end
      if (launch1)
      begin
        fifo_rp <= ~fifo_rp;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, launch1};
    end
  end

  // A token per read counts output edges; an edge coinciding with capture does not count.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tok <= 1'b0;
      pipe <= '0;
      second_due <= 1'b0;
    end
    else
    begin
      if (o_edge)
      begin
        pipe <= {pipe[0], tok};
        tok <= push;
        second_due <= launch0; // (R01)
      end
      else if (push)
      begin
        tok <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link.read_word <= '0;
      link.return_strobe_main <= 1'b0;
      link.return_strobe_inverse <= 1'b0;
      lat_bypass_out <= 1'b0;
      buffer_hit_out <= 1'b0;
    end
    else
    begin
      if (launch0)
      begin
        link.read_word <= head[WORD_W-1:0]; // (R09)
      end
      else if (launch1)
      begin
        link.read_word <= head[BURST_W-1:WORD_W]; // (R10)
      end
      link.return_strobe_main <= o_main; // (R12)
      link.return_strobe_inverse <= o_inv; // (R12)
      lat_bypass_out <= ~s_byp_n; // (R16)
      buffer_hit_out <= push & hit;
    end
  end
endmodule : burst2_sram_device

// file: core/sram_link_pkg.sv
// Shared constants, timing figures and the lane merge helper for the burst-of-two link.
package sram_link_pkg;
  localparam int ADDR_W = 20;
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = WORD_W / LANE_W;
  localparam int BURST = 2;
  localparam int BURST_W = BURST * WORD_W;
  localparam int ARRAY_WORDS = BURST * (1 << ADDR_W);
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_LOAD_A = 3'h1;
  localparam logic [PHASE_W-1:0] PHASE_MAIN_RISE = 3'h3;
  localparam logic [PHASE_W-1:0] PHASE_LOAD_B = 3'h5;
  localparam logic [PHASE_W-1:0] PHASE_INV_RISE = 3'h7;
  localparam int EDGE_W = 4;
  localparam logic [EDGE_W-1:0] LAT_EDGES_DLL = 4'h3;
  localparam logic [EDGE_W-1:0] LAT_EDGES_BYPASS = 4'h2;
  localparam int WARM_W = 4;
  localparam logic [WARM_W-1:0] WARM_CYCLES = 4'hF;
  localparam logic [1:0] SLOT_COUNT = 2'h2;

  function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_word,
                                                   input logic [WORD_W-1:0] new_word,
                                                   input logic [LANES-1:0] gate_n);
    logic [WORD_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++)
    begin
      if (!gate_n[i])
      begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : lane_merge
endpackage : sram_link_pkg

// file: core/sram_link_if.sv
// Pin-level link between the memory device and its controller.
`timescale 1ns/1ps
interface sram_link_if;
  import sram_link_pkg::*;
  logic input_timing_main;
  logic input_timing_inverse;
  logic output_timing_main;
  logic output_timing_inverse;
  logic retrieve_strobe_n;
  logic store_strobe_n;
  logic loop_bypass_n;
  logic [ADDR_W-1:0] memory_pointer_in;
  logic [LANES-1:0] lane_write_gate_n;
  logic [WORD_W-1:0] write_word;
  logic [WORD_W-1:0] read_word;
  logic return_strobe_main;
  logic return_strobe_inverse;

  modport device (
    input input_timing_main, input_timing_inverse, output_timing_main, output_timing_inverse,
    input retrieve_strobe_n, store_strobe_n, loop_bypass_n, memory_pointer_in,
    input lane_write_gate_n, write_word,
    output read_word, return_strobe_main, return_strobe_inverse
  );
  modport controller (
    output input_timing_main, input_timing_inverse, output_timing_main, output_timing_inverse,
    output retrieve_strobe_n, store_strobe_n, loop_bypass_n, memory_pointer_in,
    output lane_write_gate_n, write_word,
    input read_word, return_strobe_main, return_strobe_inverse
  );
endinterface : sram_link_if

// file: core/burst2_sram_controller.sv
// Controller end: makes the link clocks, issues commands and gathers read bursts.
`timescale 1ns/1ps
module burst2_sram_controller
  import sram_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  sram_link_if.controller link,
  input wire logic c_tie_in,
  input wire logic bypass_in,
  input wire logic rd_req_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire logic wr_req_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [BURST_W-1:0] wr_data_in,
  input wire logic [BURST*LANES-1:0] wr_gates_n_in,
  output logic req_taken_out,
  output logic [BURST_W-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  logic [WARM_W-1:0] warm_cnt;
  logic [PHASE_W-1:0] phase;
  logic [ADDR_W-1:0] wr_addr_hold;
  logic [WORD_W-1:0] wr_d1_hold;
  logic [LANES-1:0] wr_g1_hold;
  logic [EDGE_W-1:0] tx_idx;
  logic [EDGE_W-1:0] rx_idx;
  logic [(1<<EDGE_W)-1:0] due0;
  logic [(1<<EDGE_W)-1:0] due1;
  logic [1:0] outstanding;
  logic [WORD_W-1:0] word0;
  logic [2+WORD_W-1:0] sync1;
  logic [2+WORD_W-1:0] sync2;
  logic [1:0] strobe_prev;
  logic [BURST_W-1:0] spare_data;
  logic spare_valid;

  wire logic warm = (warm_cnt == WARM_CYCLES);
  wire logic [PHASE_W-1:0] next_phase = warm ? phase + 3'h1 : phase;
  wire logic [1:0] held = {1'b0, rd_valid_out} + {1'b0, spare_valid};
  wire logic credit = (held + outstanding) < SLOT_COUNT;
  wire logic load_a = warm & (phase == PHASE_LOAD_A);
  wire logic take = load_a & (rd_req_in | wr_req_in) & (~rd_req_in | credit);
  wire logic [EDGE_W-1:0] lat = bypass_in ? LAT_EDGES_BYPASS : LAT_EDGES_DLL;
  wire logic [EDGE_W-1:0] tx_next = tx_idx + 4'h1;
  wire logic issue = warm & (phase == PHASE_MAIN_RISE) & ~link.retrieve_strobe_n;
  wire logic [EDGE_W-1:0] slot0 = tx_next + lat;
  wire logic [EDGE_W-1:0] slot1 = tx_next + lat + 4'h1;
  wire logic s_sm;
  wire logic s_si;
  wire logic [WORD_W-1:0] s_word;
  assign {s_sm, s_si, s_word} = sync2;
  // Edges seen during warm-up are reset artefacts and are not counted.
  wire logic rx_edge = warm & ((s_sm & ~strobe_prev[1]) | (s_si & ~strobe_prev[0]));
  wire logic [EDGE_W-1:0] rx_next = rx_idx + 4'h1;
  wire logic got0 = rx_edge & due0[rx_next];
  wire logic push = rx_edge & due1[rx_next];
  wire logic [BURST_W-1:0] push_data = {s_word, word0};
  wire logic pop_free = rd_ready_in | ~rd_valid_out;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      warm_cnt <= '0;
      phase <= '0;
      link.input_timing_main <= 1'b0;
      link.input_timing_inverse <= 1'b1;
      link.output_timing_main <= 1'b0;
      link.output_timing_inverse <= 1'b1;
    end
    else
    begin
      if (!warm)
      begin
        warm_cnt <= warm_cnt + 4'h1;
      end
      phase <= next_phase;
      link.input_timing_main <= next_phase[2];
      link.input_timing_inverse <= ~next_phase[2];
      link.output_timing_main <= c_tie_in | next_phase[2];
      link.output_timing_inverse <= c_tie_in | ~next_phase[2];
    end
  end

  // Phase A is set up two cycles before the main rise, phase B before the inverse rise.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link.retrieve_strobe_n <= 1'b1;
      link.store_strobe_n <= 1'b1;
      link.loop_bypass_n <= 1'b1;
      link.memory_pointer_in <= '0;
      link.lane_write_gate_n <= '1;
      link.write_word <= '0;
      wr_addr_hold <= '0;
      wr_d1_hold <= '0;
      wr_g1_hold <= '1;
      req_taken_out <= 1'b0;
    end
    else
    begin
      link.loop_bypass_n <= ~bypass_in;
      req_taken_out <= take;
      if (load_a)
      begin
        link.retrieve_strobe_n <= ~(take & rd_req_in); // (R13)
        link.store_strobe_n <= ~(take & wr_req_in); // (R14)
        link.memory_pointer_in <= rd_addr_in;
        link.write_word <= wr_data_in[WORD_W-1:0]; // (R04)
        link.lane_write_gate_n <= (take & wr_req_in) ? wr_gates_n_in[LANES-1:0] : '1;
        wr_addr_hold <= wr_addr_in;
        wr_d1_hold <= wr_data_in[BURST_W-1:WORD_W];
        wr_g1_hold <= wr_gates_n_in[BURST*LANES-1:LANES];
      end
      else if (warm && phase == PHASE_LOAD_B)
      begin
        link.retrieve_strobe_n <= 1'b1;
        link.store_strobe_n <= 1'b1;
        link.memory_pointer_in <= wr_addr_hold;
        link.write_word <= wr_d1_hold; // (R08)
        link.lane_write_gate_n <= link.store_strobe_n ? '1 : wr_g1_hold; // (R15)
      end
    end
  end

  // Strobe edges arrive in the same order as the edges we launch, so indices line up.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
      strobe_prev <= '0;
      tx_idx <= '0;
      rx_idx <= '0;
      due0 <= '0;
      due1 <= '0;
      word0 <= '0;
      outstanding <= '0;
    end
    else
    begin
      sync1 <= {link.return_strobe_main, link.return_strobe_inverse, link.read_word};
      sync2 <= sync1;
      strobe_prev <= {s_sm, s_si};
      if (warm && (phase == PHASE_MAIN_RISE || phase == PHASE_INV_RISE))
      begin
        tx_idx <= tx_next;
      end
      if (rx_edge)
      begin
        rx_idx <= rx_next;
      end
      if (got0)
      begin
        word0 <= s_word;
      end
      due0 <= (due0 & ~({{((1<<EDGE_W)-1){1'b0}}, got0} << rx_next))
        | ({{((1<<EDGE_W)-1){1'b0}}, issue} << slot0);
      due1 <= (due1 & ~({{((1<<EDGE_W)-1){1'b0}}, push} << rx_next))
        | ({{((1<<EDGE_W)-1){1'b0}}, issue} << slot1);
      outstanding <= outstanding + {1'b0, take & rd_req_in} - {1'b0, push};
    end
  end

  // Two-slot return buffer; credits stop new reads so a stalled reader loses nothing.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
      spare_data <= '0;
      spare_valid <= 1'b0;
    end
    else if (pop_free)
    begin
      if (spare_valid)
      begin
        rd_data_out <= spare_data;
        rd_valid_out <= 1'b1;
        spare_data <= push_data;
        spare_valid <= push;
      end
      else
      begin
        rd_data_out <= push_data;
        rd_valid_out <= push;
      end
    end
    else if (push)
    begin
      spare_data <= push_data;
      spare_valid <= 1'b1;
    end
  end
endmodule : burst2_sram_controller

// file: tb/burst2_ddr_split_port_sram_checker.sv
// Concurrent checks on the link between the memory device and its controller.
`timescale 1ns/1ps
module burst2_ddr_split_port_sram_checker
  import sram_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic input_timing_main,
  input wire logic input_timing_inverse,
  input wire logic output_timing_main,
  input wire logic output_timing_inverse,
  input wire logic retrieve_strobe_n,
  input wire logic store_strobe_n,
  input wire logic [LANES-1:0] lane_write_gate_n,
  input wire logic [WORD_W-1:0] write_word,
  input wire logic [ADDR_W-1:0] memory_pointer_in,
  input wire logic [WORD_W-1:0] read_word,
  input wire logic return_strobe_main,
  input wire logic return_strobe_inverse
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence strobe_edge;
    $rose(return_strobe_main) || $rose(return_strobe_inverse);
  endsequence
  sequence word_one_held;
    (!store_strobe_n && $stable(write_word) && $stable(lane_write_gate_n))[*3];
  endsequence

  chk_clock_pair_opposite: assert property (input_timing_main != input_timing_inverse)
    else $error("link clocks not complementary");
  chk_link_half_period: assert property ($rose(input_timing_main) |->
    input_timing_main[*4] ##1 !input_timing_main)
    else $error("link clock half period wrong");
  chk_write_word_one: assert property ($fell(store_strobe_n) |=>
    word_one_held ##1 store_strobe_n)
    else $error("first write word not held with its strobe");
  chk_command_at_rise: assert property ($fell(retrieve_strobe_n & store_strobe_n) |->
    ##[1:3] ($rose(input_timing_main) && !(retrieve_strobe_n && store_strobe_n)))
    else $error("command strobe missed the main clock rise");
  chk_gates_idle_high: assert property (store_strobe_n[*5] |-> &lane_write_gate_n)
    else $error("lane gates active outside a write");
  chk_data_with_strobe: assert property ($changed(read_word) |-> strobe_edge)
    else $error("read data moved without a return strobe edge");
  chk_data_word_hold: assert property ($changed(read_word) |=> $stable(read_word)[*3])
    else $error("read word held for less than half a link period");
  chk_strobes_untied: assert property ((output_timing_main != output_timing_inverse)[*6] |->
    return_strobe_main != return_strobe_inverse)
    else $error("return strobes not complementary");
  chk_strobes_tied: assert property ((output_timing_main && output_timing_inverse)[*6] |->
    return_strobe_main != return_strobe_inverse)
    else $error("tied output clocks not replaced by input clocks");
endmodule : burst2_ddr_split_port_sram_checker

// file: tb/burst2_ddr_split_port_sram_tb.sv
// Bench joining controller and device over the link, with read bursts scored in issue order.
`timescale 1ns/1ps
module burst2_ddr_split_port_sram_tb;
  import sram_link_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic c_tie_in = 1'b0;
  logic bypass_in = 1'b0;
  logic rd_req_in = 1'b0;
  logic wr_req_in = 1'b0;
  logic [ADDR_W-1:0] rd_addr_in = '0;
  logic [ADDR_W-1:0] wr_addr_in = '0;
  logic [BURST_W-1:0] wr_data_in = '0;
  logic [BURST*LANES-1:0] wr_gates_n_in = 4'hF;
  logic rd_ready_in = 1'b1;
  logic req_taken_out;
  logic [BURST_W-1:0] rd_data_out;
  logic rd_valid_out;
  logic lat_bypass_out;
  logic buffer_hit_out;
  logic stall = 1'b0;
  int seed = 32'h05F09375;
  int num_errors = 0;
  int samples_checked = 0;
  int hits = 0;
  logic [BURST_W-1:0] exp_q[$];
  logic [BURST_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addr [8];

  sram_link_if link ();
  burst2_sram_device burst2_sram_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
    .lat_bypass_out(lat_bypass_out), .buffer_hit_out(buffer_hit_out));
  burst2_sram_controller burst2_sram_controller_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link(link), .c_tie_in(c_tie_in), .bypass_in(bypass_in), .rd_req_in(rd_req_in),
    .rd_addr_in(rd_addr_in), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .wr_gates_n_in(wr_gates_n_in), .req_taken_out(req_taken_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in));
  burst2_ddr_split_port_sram_checker burst2_ddr_split_port_sram_checker_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .input_timing_main(link.input_timing_main),
    .input_timing_inverse(link.input_timing_inverse),
    .output_timing_main(link.output_timing_main),
    .output_timing_inverse(link.output_timing_inverse),
    .retrieve_strobe_n(link.retrieve_strobe_n), .store_strobe_n(link.store_strobe_n),
    .lane_write_gate_n(link.lane_write_gate_n), .write_word(link.write_word),
    .memory_pointer_in(link.memory_pointer_in), .read_word(link.read_word),
    .return_strobe_main(link.return_strobe_main),
    .return_strobe_inverse(link.return_strobe_inverse));

  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  // A random receiver keeps the two-entry read buffer busy instead of always draining it.
  always @(negedge clk_in)
  begin
    rd_ready_in <= !stall && ($random(seed) % 3 != 0);
  end

  // Reads that land on the parked write are counted, so the merge path is known to be taken.
  always @(posedge clk_in)
  begin
    if (buffer_hit_out === 1'b1)
      hits++;
  end

  task automatic check(input logic [BURST_W-1:0] seen, input logic [BURST_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clk_in)
  begin
    if (rst_n_in === 1'b1 && rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("wrong value at %0t: burst with nothing outstanding", $time);
      end
      else
        check(rd_data_out, exp_q.pop_front());
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic timeout();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict();
  endtask : timeout

  function automatic logic [BURST_W-1:0] merge(input logic [BURST_W-1:0] o,
                                               input logic [BURST_W-1:0] n,
                                               input logic [BURST*LANES-1:0] g);
    for (int k = 0; k < BURST * LANES; k++)
    begin
      if (!g[k])
        o[k*LANE_W +: LANE_W] = n[k*LANE_W +: LANE_W];
    end
    return o;
  endfunction : merge

  function automatic logic [BURST_W-1:0] rnd();
    return BURST_W'({$random(seed), $random(seed)});
  endfunction : rnd

  // Expectations are noted at the take, so a read sees every write taken before it.
  task automatic issue(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                       input logic [ADDR_W-1:0] wa, input logic [BURST_W-1:0] wd,
                       input logic [BURST*LANES-1:0] wg, input int lim, output logic taken);
    taken = 1'b0;
    @(negedge clk_in);
    rd_req_in = rd;
    rd_addr_in = ra;
    wr_req_in = wr;
    wr_addr_in = wa;
    wr_data_in = wd;
    wr_gates_n_in = wg;
    for (int i = 0; i < lim && !taken; i++)
    begin
      @(negedge clk_in);
      taken = (req_taken_out === 1'b1);
    end
    if (taken)
    begin
      rd_req_in = 1'b0;
      wr_req_in = 1'b0;
      if (rd)
        exp_q.push_back(mem[ra]);
      if (wr)
        mem[wa] = merge(mem.exists(wa) ? mem[wa] : '0, wd, wg);
    end
  endtask : issue

  task automatic go(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                    input logic [ADDR_W-1:0] wa, input logic [BURST_W-1:0] wd,
                    input logic [BURST*LANES-1:0] wg);
    logic t;
    issue(rd, ra, wr, wa, wd, wg, 300, t);
    if (!t)
      timeout();
  endtask : go

  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
      @(negedge clk_in);
    if (exp_q.size() > 0)
      timeout();
  endtask : drain

  initial
  begin
    logic t;
    int hit_base;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    addr[0] = '0;
    addr[1] = '1;
    for (int i = 2; i < 8; i++)
      addr[i] = ADDR_W'($random(seed));
    for (int i = 0; i < 8; i++)
      go(1'b0, '0, 1'b1, addr[i], rnd(), 4'h0);
    $display("Test full writes done");
    // Each read after the first hits the write still parked in the buffer by the slot before.
    hit_base = hits;
    for (int i = 0; i < 8; i++)
      go(1'b1, addr[i], 1'b1, addr[(i + 1) % 8], rnd(), 4'($random(seed)));
    drain();
    // The first read misses, since the parked write then belongs to another address.
    check(BURST_W'(hits - hit_base), BURST_W'(7));
    $display("Test lane gates and coherence done");
    stall = 1'b1;
    go(1'b1, addr[2], 1'b0, '0, '0, 4'hF);
    go(1'b1, addr[3], 1'b0, '0, '0, 4'hF);
    issue(1'b1, addr[4], 1'b0, '0, '0, 4'hF, 64, t);
    check(BURST_W'(t), '0);
    stall = 1'b0;
    go(1'b1, addr[4], 1'b0, '0, '0, 4'hF);
    drain();
    $display("Test receiver stall done");
    c_tie_in = 1'b1;
    for (int i = 0; i < 4; i++)
      go(1'b1, addr[i], 1'b0, '0, '0, 4'hF);
    drain();
    c_tie_in = 1'b0;
    $display("Test tied output clocks done");
    bypass_in = 1'b1;
    for (int i = 0; i < 40 && lat_bypass_out !== 1'b1; i++)
      @(negedge clk_in);
    check(BURST_W'(lat_bypass_out), BURST_W'(1'b1));
    for (int i = 4; i < 8; i++)
      go(1'b1, addr[i], 1'b1, addr[i], rnd(), 4'($random(seed)));
    drain();
    $display("Test loop bypass done");
    print_verdict();
  end
endmodule : burst2_ddr_split_port_sram_tb
